// [design/abp_map.svh]
/*
 * Constants for the arbitrary block parser: characters, limits, bus codes.
 * Assumes inclusion by the error queue and parser modules; definitions only.
 */
`ifndef ABP_MAP_SVH
`define ABP_MAP_SVH

`define ABP_CHAR_HASH 8'h23
`define ABP_CHAR_ZERO 8'h30
`define ABP_CHAR_NINE 8'h39
`define ABP_CHAR_LF 8'h0A
`define ABP_CHAR_CR 8'h0D
`define ABP_CHAR_SPACE 8'h20
`define ABP_CHAR_TAB 8'h09
`define ABP_SAMPLE_MAX 16'sh1FFF
`define ABP_SAMPLE_MIN 16'shE001
`define ABP_LISTEN_OFFSET 8'h20
`define ABP_TALK_OFFSET 8'h40
`define ABP_UNTALK_CODE 8'h5F
`define ABP_UNLISTEN_CODE 8'h3F
`define ABP_ERR_SYNTAX 4'h1
`define ABP_ERR_ODD 4'h2
`define ABP_ERR_RANGE 4'h3
`define ABP_ERR_QUEUE_DEPTH 8
`define ABP_ERR_PTR_W 3
`define ABP_ERR_CNT_W 4

`endif

// [design/abp_pkg.sv]
/*
 * Types shared by the arbitrary block parser files.
 * Assumes the map header supplies every numeric constant.
 */
package abp_pkg;
   // Parser states from header match to block end.
   typedef enum logic [3:0] {
      ABP_IDLE,
      ABP_WS,
      ABP_HASH,
      ABP_LEN_DIGITS,
      ABP_COUNT,
      ABP_DATA_DEF,
      ABP_DATA_INDEF,
      ABP_DISCARD
   } abp_state_t;
   // Talker output states for binary readback.
   typedef enum logic [1:0] {
      ABP_TX_IDLE,
      ABP_TX_HASH,
      ABP_TX_ZERO,
      ABP_TX_DATA
   } abp_tx_state_t;
endpackage : abp_pkg

// [design/abp_err_queue.sv]
/*
 * Error queue for the block parser: holds error codes until the host
 * reads them through the error queue query.
 * Assumes one clock and an asynchronous, already-synchronised reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "abp_map.svh"

module abp_err_queue
   import abp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [3:0] push_code,
   input wire logic error_queue_query,
   output logic [3:0] err_code,
   output logic err_valid,
   output logic err_overflow
);
   logic [3:0] mem_reg [0:`ABP_ERR_QUEUE_DEPTH-1];
   logic [`ABP_ERR_PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [`ABP_ERR_CNT_W-1:0] cnt_reg, cnt_next;
   logic [3:0] code_reg, code_next;
   logic ovf_reg, ovf_next;
   logic do_push, do_pop;

   // A full queue drops new entries, unless a query pops one in the same cycle, and flags any drop until the next query.
   always_comb begin
      do_pop = error_queue_query && (cnt_reg != '0);
      do_push = push && ((cnt_reg != `ABP_ERR_CNT_W'(`ABP_ERR_QUEUE_DEPTH)) || do_pop);
      wr_next = do_push ? wr_reg + 1'b1 : wr_reg;
      rd_next = do_pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg + {3'h0, do_push} - {3'h0, do_pop};
      code_next = error_queue_query ? (do_pop ? mem_reg[rd_reg] : 4'h0) : code_reg;
      ovf_next = (ovf_reg && !error_queue_query) || (push && !do_push);
   end

   // Registers; the storage array is written in the block below, without reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         code_reg <= 4'h0;
         ovf_reg <= 1'b0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         code_reg <= code_next;
         ovf_reg <= ovf_next;
      end
   end

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_reg[wr_reg] <= push_code;
      end
   end

   assign err_code = code_reg;
   assign err_valid = (cnt_reg != '0);
   assign err_overflow = ovf_reg;
endmodule : abp_err_queue
`default_nettype wire

// [design/abp_parser.sv]
/*
 * Arbitrary block parser: takes bytes of the waveform load command after
 * its header has been recognised, checks the preamble, assembles samples
 * high byte first, posts errors, and plays samples back as an indefinite
 * block. Also decodes own talk/listen addresses and untalk on the bus.
 * Assumes bytes arrive already handshaken, one per strobe, with EOI
 * flagged on the same strobe; header matching is done upstream.
 */
// How it works
// - Command is header, whitespace, preamble, data, terminator for both styles; definite blocks end on the byte count and any terminator is ignored.
// - Both definite (counted) and indefinite (terminated) blocks are accepted.
// - Each payload byte is taken whole as a raw octet.
// - Two bytes form one sample, most significant byte first.
// - Samples must lie from -8191 to 8191; zero is baseline.
// - Definite preamble first field gives the digit count of the length.
// - Length digits 0-9, that many, form the decimal byte count.
// - Indefinite preamble is the single character zero, then data.
// - Indefinite block ends on EOI over GPIB, or CR/LF over serial.
// - Binary readback is returned as an indefinite block.
// - A failed load posts an entry to the error queue.
// - Own talk address is primary plus 64, listen plus 32, with ATN.
// - Untalk with ATN idles the talker and stops output data.
`timescale 1ns/1ps
`default_nettype none
`include "abp_map.svh"

module abp_parser
   import abp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [4:0] primary_addr,
   input wire logic serial_mode,
   input wire logic cmd_start,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_eoi,
   input wire logic byte_atn,
   input wire logic error_queue_query,
   input wire logic readback_start,
   input wire logic [15:0] readback_sample,
   input wire logic readback_last,
   input wire logic tx_ready,
   output logic sample_valid,
   output logic [15:0] sample_data,
   output logic block_done,
   output logic block_busy,
   output logic listen_active,
   output logic talk_active,
   output logic readback_take,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_eoi,
   output logic [3:0] err_code,
   output logic err_valid,
   output logic err_overflow
);
   logic rst_meta_reg, rst_sync_reg;
   abp_state_t st_reg, st_next;
   logic [3:0] ndig_reg, ndig_next;
   logic [31:0] count_reg, count_next;
   logic [7:0] hi_reg, hi_next;
   logic half_reg, half_next;
   logic sv_reg, sv_next;
   logic [15:0] sd_reg, sd_next;
   logic done_reg, done_next;
   logic err_push;
   logic [3:0] err_push_code;
   logic lad_reg, lad_next, tad_reg, tad_next;
   abp_tx_state_t tx_reg, tx_next;
   logic [7:0] txd_reg, txd_next;
   logic txe_reg, txe_next, txv_reg, txv_next;
   logic [7:0] lo_keep_reg, lo_keep_next;
   logic last_keep_reg, last_keep_next;
   logic lo_pend_reg, lo_pend_next;

   // True for an ASCII decimal digit.
   function automatic logic is_digit(input logic [7:0] b);
      is_digit = (b >= `ABP_CHAR_ZERO) && (b <= `ABP_CHAR_NINE);
   endfunction : is_digit

   // True for a serial line terminator.
   function automatic logic is_term(input logic [7:0] b);
      is_term = (b == `ABP_CHAR_LF) || (b == `ABP_CHAR_CR);
   endfunction : is_term

   // Reset is released through two flops so its removal is clean.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Bus address decode; only bytes sent with ATN are interface messages.
   always_comb begin
      lad_next = lad_reg;
      tad_next = tad_reg;
      if (byte_valid && byte_atn) begin
         if (byte_data == (`ABP_LISTEN_OFFSET + {3'h0, primary_addr})) begin
            lad_next = 1'b1;
         end else if (byte_data == `ABP_UNLISTEN_CODE) begin
            lad_next = 1'b0;
         end
         if (byte_data == (`ABP_TALK_OFFSET + {3'h0, primary_addr})) begin
            tad_next = 1'b1;
         end else if (byte_data == `ABP_UNTALK_CODE) begin
            tad_next = 1'b0;
         end
      end
   end

   // Block parser next state; data bytes need no ATN.
   always_comb begin
      st_next = st_reg;
      ndig_next = ndig_reg;
      count_next = count_reg;
      hi_next = hi_reg;
      half_next = half_reg;
      sv_next = 1'b0;
      sd_next = sd_reg;
      done_next = 1'b0;
      err_push = 1'b0;
      err_push_code = 4'h0;
      if (cmd_start) begin
         st_next = ABP_WS;
         half_next = 1'b0;
      end else if (byte_valid && !byte_atn) begin
         case (st_reg)
            ABP_IDLE: begin
               st_next = ABP_IDLE;
            end
            ABP_WS: begin
               if (byte_data == `ABP_CHAR_SPACE || byte_data == `ABP_CHAR_TAB) begin
                  st_next = ABP_HASH;
               end else begin
                  st_next = ABP_DISCARD;
                  err_push = 1'b1;
                  err_push_code = `ABP_ERR_SYNTAX;
               end
            end
            ABP_HASH: begin
               if (byte_data == `ABP_CHAR_HASH) begin
                  st_next = ABP_LEN_DIGITS;
               end else if (byte_data != `ABP_CHAR_SPACE && byte_data != `ABP_CHAR_TAB) begin
                  st_next = ABP_DISCARD;
                  err_push = 1'b1;
                  err_push_code = `ABP_ERR_SYNTAX;
               end
            end
            ABP_LEN_DIGITS: begin
               count_next = '0;
               ndig_next = byte_data[3:0];
               if (!is_digit(byte_data)) begin
                  st_next = ABP_DISCARD;
                  err_push = 1'b1;
                  err_push_code = `ABP_ERR_SYNTAX;
               end else if (byte_data == `ABP_CHAR_ZERO) begin
                  st_next = ABP_DATA_INDEF;
               end else begin
                  st_next = ABP_COUNT;
               end
            end
            ABP_COUNT: begin
               if (!is_digit(byte_data)) begin
                  st_next = ABP_DISCARD;
                  err_push = 1'b1;
                  err_push_code = `ABP_ERR_SYNTAX;
               end else begin
                  count_next = 32'((count_reg << 3) + (count_reg << 1) + {28'h0, byte_data[3:0]});
                  ndig_next = ndig_reg - 4'h1;
                  if (ndig_reg == 4'h1) begin
                     st_next = ABP_DATA_DEF;
                     if (count_next == '0) begin
                        st_next = ABP_IDLE;
                        done_next = 1'b1;
                     end
                  end
               end
            end
            ABP_DATA_DEF, ABP_DATA_INDEF: begin
               if (st_reg == ABP_DATA_INDEF && !half_reg &&
                   ((!serial_mode && byte_eoi) || (serial_mode && is_term(byte_data)))) begin
                  st_next = ABP_IDLE;
                  done_next = 1'b1;
               end else begin
                  half_next = !half_reg;
                  if (!half_reg) begin
                     hi_next = byte_data;
                  end else begin
                     sd_next = {hi_reg, byte_data};
                     if ($signed(sd_next) > `ABP_SAMPLE_MAX ||
                         $signed(sd_next) < `ABP_SAMPLE_MIN) begin
                        err_push = 1'b1;
                        err_push_code = `ABP_ERR_RANGE;
                     end else begin
                        sv_next = 1'b1;
                     end
                  end
                  if (st_reg == ABP_DATA_DEF) begin
                     count_next = count_reg - 32'h0000_0001;
                     if (count_reg == 32'h0000_0001) begin
                        st_next = ABP_IDLE;
                        done_next = 1'b1;
                        if (!half_reg) begin
                           sv_next = 1'b0;
                           err_push = 1'b1;
                           err_push_code = `ABP_ERR_ODD;
                        end
                     end
                  end else if (byte_eoi && !serial_mode) begin
                     st_next = ABP_IDLE;
                     if (!half_reg) begin
                        err_push = 1'b1;
                        err_push_code = `ABP_ERR_ODD;
                     end else begin
                        done_next = 1'b1;
                     end
                  end
               end
               if (st_reg == ABP_DATA_INDEF && half_reg &&
                   ((!serial_mode && byte_eoi && byte_data == `ABP_CHAR_LF) ||
                    (serial_mode && is_term(byte_data)))) begin
                  st_next = ABP_IDLE;
                  half_next = 1'b0;
                  sv_next = 1'b0;
                  done_next = 1'b0;
                  err_push = 1'b1;
                  err_push_code = `ABP_ERR_ODD;
               end
            end
            ABP_DISCARD: begin
               // Swallow the rest of a broken block until its end marker.
               if (byte_eoi || is_term(byte_data)) begin
                  st_next = ABP_IDLE;
               end
            end
            default: begin
               st_next = ABP_IDLE;
            end
         endcase
      end
   end

   // Readback talker: '#', '0', samples high byte first, EOI on final LF.
   always_comb begin
      tx_next = tx_reg;
      txd_next = txd_reg;
      txe_next = 1'b0;
      txv_next = txv_reg;
      lo_keep_next = lo_keep_reg;
      last_keep_next = last_keep_reg;
      lo_pend_next = lo_pend_reg;
      readback_take = 1'b0;
      if (!tad_reg) begin
         tx_next = ABP_TX_IDLE;
         txv_next = 1'b0;
      end else if (!txv_reg || tx_ready) begin
         txv_next = 1'b0;
         case (tx_reg)
            ABP_TX_IDLE: begin
               if (readback_start) begin
                  tx_next = ABP_TX_HASH;
                  txd_next = `ABP_CHAR_HASH;
                  txv_next = 1'b1;
               end
            end
            ABP_TX_HASH: begin
               tx_next = ABP_TX_ZERO;
               txd_next = `ABP_CHAR_ZERO;
               txv_next = 1'b1;
            end
            ABP_TX_ZERO, ABP_TX_DATA: begin
               tx_next = ABP_TX_DATA;
               txv_next = 1'b1;
               if (lo_pend_reg) begin
                  txd_next = lo_keep_reg;
                  lo_pend_next = 1'b0;
               end else if (last_keep_reg && tx_reg == ABP_TX_DATA) begin
                  txd_next = `ABP_CHAR_LF;
                  txe_next = 1'b1;
                  last_keep_next = 1'b0;
                  tx_next = ABP_TX_IDLE;
               end else begin
                  readback_take = 1'b1;
                  txd_next = readback_sample[15:8];
                  lo_keep_next = readback_sample[7:0];
                  last_keep_next = readback_last;
                  lo_pend_next = 1'b1;
               end
            end
            default: begin
               tx_next = ABP_TX_IDLE;
            end
         endcase
      end else begin
         txe_next = txe_reg;
      end
   end

   // State registers for decode, parser and talker.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         st_reg <= ABP_IDLE;
         ndig_reg <= 4'h0;
         count_reg <= 32'h0000_0000;
         hi_reg <= 8'h00;
         half_reg <= 1'b0;
         sv_reg <= 1'b0;
         sd_reg <= 16'h0000;
         done_reg <= 1'b0;
         lad_reg <= 1'b0;
         tad_reg <= 1'b0;
         tx_reg <= ABP_TX_IDLE;
         txd_reg <= 8'h00;
         txe_reg <= 1'b0;
         txv_reg <= 1'b0;
         lo_keep_reg <= 8'h00;
         last_keep_reg <= 1'b0;
         lo_pend_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         ndig_reg <= ndig_next;
         count_reg <= count_next;
         hi_reg <= hi_next;
         half_reg <= half_next;
         sv_reg <= sv_next;
         sd_reg <= sd_next;
         done_reg <= done_next;
         lad_reg <= lad_next;
         tad_reg <= tad_next;
         tx_reg <= tx_next;
         txd_reg <= txd_next;
         txe_reg <= txe_next;
         txv_reg <= txv_next;
         lo_keep_reg <= lo_keep_next;
         last_keep_reg <= last_keep_next;
         lo_pend_reg <= lo_pend_next;
      end
   end

   abp_err_queue u_err_queue (
      .clk(clk),
      .rst_n(rst_sync_reg),
      .push(err_push),
      .push_code(err_push_code),
      .error_queue_query(error_queue_query),
      .err_code(err_code),
      .err_valid(err_valid),
      .err_overflow(err_overflow)
   );

   assign sample_valid = sv_reg;
   assign sample_data = sd_reg;
   assign block_done = done_reg;
   assign block_busy = (st_reg != ABP_IDLE);
   assign listen_active = lad_reg;
   assign talk_active = tad_reg;
   assign tx_valid = txv_reg;
   assign tx_data = txd_reg;
   assign tx_eoi = txe_reg;
endmodule : abp_parser
`default_nettype wire

// [tb/abp_parser_monitor.sv]
/*
 * Checker for the block parser: sample pairing and range, bus addressing
 * and talker output. Assumes a bind to abp_parser and a single clock.
 */
`timescale 1ns/1ps
`default_nettype none

module abp_parser_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [4:0] primary_addr,
   input wire logic cmd_start,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_atn,
   input wire logic readback_start,
   input wire logic tx_ready,
   input wire logic sample_valid,
   input wire logic [15:0] sample_data,
   input wire logic block_done,
   input wire logic block_busy,
   input wire logic listen_active,
   input wire logic talk_active,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_eoi
);
   logic [7:0] prev_reg;
   logic [7:0] prev_next;

   // Last payload byte taken; ATN bytes are bus messages, never payload.
   always_comb begin
      prev_next = prev_reg;
      if (byte_valid && !byte_atn && !cmd_start) prev_next = byte_data;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) prev_reg <= 8'h00;
      else prev_reg <= prev_next;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_own_talk;
      byte_valid && byte_atn && byte_data == {3'b010, primary_addr};
   endsequence
   sequence s_own_listen;
      byte_valid && byte_atn && byte_data == {3'b001, primary_addr};
   endsequence
   sequence s_hash_out;
      tx_valid && tx_data == 8'h23;
   endsequence

   chk_sample_range: assert property (
      sample_valid |-> $signed(sample_data) <= 16'sh1FFF && $signed(sample_data) >= 16'shE001)
      else $error("sample out of range");
   chk_msb_first: assert property (
      sample_valid |-> sample_data == {$past(prev_reg), $past(byte_data)})
      else $error("sample not assembled high byte first");
   chk_sample_gap: assert property (sample_valid |=> !sample_valid)
      else $error("two samples from fewer than two bytes");
   chk_own_talk: assert property (s_own_talk |=> talk_active)
      else $error("own talk address not taken");
   chk_own_listen: assert property (s_own_listen |=> listen_active)
      else $error("own listen address not taken");
   chk_untalk_idle: assert property (
      byte_valid && byte_atn && byte_data == 8'h5F |=> !talk_active)
      else $error("talker still active after untalk");
   chk_idle_ignore: assert property (
      byte_valid && !byte_atn && !block_busy && !cmd_start |=> !sample_valid && !block_done)
      else $error("byte outside a command produced output");
   chk_tx_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_eoi) || !talk_active)
      else $error("talker byte changed before acceptance");
   chk_eoi_on_lf: assert property (tx_valid && tx_eoi |-> tx_data == 8'h0A)
      else $error("end flag not on line feed");
   chk_rb_hash: assert property (
      readback_start && talk_active && !tx_valid |-> ##[1:3] s_hash_out)
      else $error("readback did not open with a hash");
endmodule : abp_parser_monitor

bind abp_parser abp_parser_monitor u_mon (.clk, .resetn, .primary_addr, .cmd_start,
   .byte_valid, .byte_data, .byte_atn, .readback_start, .tx_ready, .sample_valid,
   .sample_data, .block_done, .block_busy, .listen_active, .talk_active, .tx_valid,
   .tx_data, .tx_eoi);

`default_nettype wire

// [tb/abp_host_model.sv]
/*
 * Host controller model: sends load commands and bus messages byte by
 * byte, and sinks talker bytes, promptly or with stalls.
 * Assumes the bench calls its tasks and reads rx_q.
 */
`timescale 1ns/1ps
`default_nettype none

module abp_host_model (
   input wire logic clk,
   output logic cmd_start,
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic byte_eoi,
   output logic byte_atn,
   output logic tx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_eoi
);
   logic [8:0] rx_q[$];
   int slow = 0;
   int tick = 0;

   initial begin
      cmd_start = 1'b0;
      byte_valid = 1'b0;
      byte_data = 8'h00;
      byte_eoi = 1'b0;
      byte_atn = 1'b0;
      tx_ready = 1'b0;
   end

   // Slow mode accepts one talker byte in three to exercise stalls.
   always @(negedge clk) begin
      tick++;
      tx_ready <= (slow == 0) || (tick % 3 == 0);
   end
   always @(posedge clk) begin
      if (tx_valid && tx_ready) rx_q.push_back({tx_eoi, tx_data});
   end

   task automatic put(input logic [7:0] b, input logic eoi, input logic atn);
      @(negedge clk);
      cmd_start = 1'b0;
      byte_valid = 1'b1;
      byte_data = b;
      byte_eoi = eoi;
      byte_atn = atn;
   endtask : put

   // Idle data lines show the inverse of the last byte, never a stale copy.
   task automatic rest;
      @(negedge clk);
      cmd_start = 1'b0;
      byte_valid = 1'b0;
      byte_eoi = 1'b0;
      byte_atn = 1'b0;
      byte_data = ~byte_data;
   endtask : rest

   task automatic start;
      @(negedge clk);
      cmd_start = 1'b1;
      byte_valid = 1'b0;
      byte_data = ~byte_data;
   endtask : start

   // Free byte run with the end flag on the last byte.
   task automatic raw(input logic [7:0] q[$]);
      foreach (q[i]) put(q[i], i == q.size() - 1, 1'b0);
      rest();
   endtask : raw

   // no class mask here, so every error class reports
   task automatic load(input bit def, input bit ser, input logic [7:0] d[$]);
      string n;
      n = $sformatf("%0d", d.size());
      start();
      put(8'h20, 1'b0, 1'b0);
      put(8'h23, 1'b0, 1'b0);
      if (def) begin
         put(8'h30 + 8'(n.len()), 1'b0, 1'b0);
         foreach (n[i]) put(8'(n[i]), 1'b0, 1'b0);
      end
      else put(8'h30, 1'b0, 1'b0);
      // raw bytes, high first, count as given
      foreach (d[i]) put(d[i], 1'b0, 1'b0);
      if (ser) put(8'h0D, 1'b0, 1'b0);
      put(8'h0A, !ser, 1'b0);
      rest();
   endtask : load
endmodule : abp_host_model

`default_nettype wire

// [tb/testbench.sv]
/*
 * Self-checking bench for the block parser with the host model.
 * Assumes the design files and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam logic [4:0] ADDR = 5'h05;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic serial_mode = 1'b0;
   logic error_queue_query = 1'b0;
   logic readback_start = 1'b0;
   logic [15:0] readback_sample;
   logic readback_last;
   logic cmd_start, byte_valid, byte_eoi, byte_atn, tx_ready;
   logic sample_valid, block_done, block_busy, listen_active, talk_active;
   logic readback_take, tx_valid, tx_eoi, err_valid, err_overflow;
   logic [7:0] byte_data;
   logic [7:0] tx_data;
   logic [15:0] sample_data;
   logic [3:0] err_code;
   logic [15:0] got_q[$];
   logic [15:0] rb_d[4] = '{16'h1234, 16'hFFFF, 16'hE001, 16'h0000};
   logic [1:0] rb_i = 2'b00;
   logic [7:0] d[$];
   int bad_count = 0;
   int samples_checked = 0;
   int done_count = 0;

   always #12.5 clk = ~clk;

   abp_parser uut (.clk, .resetn, .primary_addr(ADDR), .serial_mode, .cmd_start,
      .byte_valid, .byte_data, .byte_eoi, .byte_atn, .error_queue_query,
      .readback_start, .readback_sample, .readback_last, .tx_ready, .sample_valid,
      .sample_data, .block_done, .block_busy, .listen_active, .talk_active,
      .readback_take, .tx_valid, .tx_data, .tx_eoi, .err_code, .err_valid,
      .err_overflow);
   abp_host_model host (.clk, .cmd_start, .byte_valid, .byte_data, .byte_eoi,
      .byte_atn, .tx_ready, .tx_valid, .tx_data, .tx_eoi);

   // Readback source advances on the edge that consumes a sample.
   always_comb begin
      readback_sample = rb_d[rb_i];
      readback_last = (rb_i == 2'd2);
   end
   always @(posedge clk) begin
      if (readback_take === 1'b1) rb_i <= rb_i + 2'd1;
      if (sample_valid === 1'b1) got_q.push_back(sample_data);
      if (block_done === 1'b1) done_count++;
   end

   task automatic final_report;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Bounded wait for the parser to go idle, then let pulses land.
   task automatic settle;
      int n;
      n = 0;
      while (block_busy !== 1'b0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      check("parser idle", block_busy, 1'b0);
      if (block_busy !== 1'b0) final_report();
      repeat (2) @(negedge clk);
   endtask : settle

   // Expected samples are every in-range high/low pair of d.
   task automatic run(input bit def, input bit ser, input int nd);
      logic [15:0] e[$];
      logic [15:0] v;
      for (int i = 0; i + 1 < d.size(); i += 2) begin
         v = {d[i], d[i+1]};
         if ($signed(v) <= 16'sh1FFF && $signed(v) >= 16'shE001) e.push_back(v);
      end
      got_q = {};
      done_count = 0;
      serial_mode = ser;
      host.load(def, ser, d);
      settle();
      check("sample count", got_q.size(), e.size());
      foreach (e[i]) check("sample", got_q[i], e[i]);
      if (nd >= 0) check("block done", done_count, nd);
   endtask : run

   task automatic pop_err(input logic [3:0] exp);
      @(negedge clk);
      error_queue_query = 1'b1;
      @(negedge clk);
      error_queue_query = 1'b0;
      check("error code", err_code, exp);
   endtask : pop_err

   task automatic t_addr;
      host.put({3'b001, ADDR}, 1'b0, 1'b1);
      host.rest();
      check("listen", listen_active, 1'b1);
      host.put({3'b010, ADDR}, 1'b0, 1'b1);
      host.put(8'h5F, 1'b0, 1'b1);
      host.rest();
      check("untalk", talk_active, 1'b0);
      host.put({3'b010, ADDR}, 1'b0, 1'b1);
      host.rest();
      check("talk", talk_active, 1'b1);
   endtask : t_addr

   // Missing hash, then a letter as preamble: both thrown away.
   task automatic t_syntax;
      got_q = {};
      host.start();
      d = {8'h20, 8'h41, 8'h00, 8'h0A};
      host.raw(d);
      host.start();
      d = {8'h20, 8'h23, 8'h5A, 8'h00, 8'h0A};
      host.raw(d);
      settle();
      check("discarded", got_q.size(), 0);
      pop_err(4'h1);
      pop_err(4'h1);
      check("queue empty", err_valid, 1'b0);
   endtask : t_syntax

   // Slow sink; stream must be hash, zero, pairs, then LF with end flag.
   task automatic t_readback;
      logic [8:0] e[9] = '{9'h023, 9'h030, 9'h012, 9'h034, 9'h0FF, 9'h0FF,
         9'h0E0, 9'h001, 9'h10A};
      int n;
      host.slow = 1;
      host.rx_q = {};
      @(negedge clk);
      readback_start = 1'b1;
      @(negedge clk);
      readback_start = 1'b0;
      n = 0;
      while (host.rx_q.size() < 9 && n < 300) begin
         @(negedge clk);
         n++;
      end
      check("readback length", host.rx_q.size(), 9);
      foreach (e[i]) check("readback byte", host.rx_q[i], e[i]);
      if (host.rx_q.size() < 9) final_report();
   endtask : t_readback

   initial begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      check("reset quiet", {sample_valid, block_busy, tx_valid, err_valid, err_overflow}, 0);
      t_addr();
      t_syntax();
      // Ten bytes need a two-digit count with a zero digit; peaks included.
      d = {8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h1F, 8'hFF, 8'hE0, 8'h01};
      run(1'b1, 1'b0, 1);
      // A line feed without the end flag is payload on the bus.
      d = {8'h00, 8'h05, 8'h0A, 8'h0A, 8'hFF, 8'hFF, 8'h12, 8'h34};
      run(1'b0, 1'b0, 1);
      d = {8'h01, 8'h02, 8'hE0, 8'h01};
      run(1'b0, 1'b1, 1);
      d = {8'h20, 8'h00, 8'hE0, 8'h00, 8'h1F, 8'hFF};
      run(1'b1, 1'b0, -1);
      pop_err(4'h3);
      pop_err(4'h3);
      d = {8'h00, 8'h07, 8'h44};
      run(1'b0, 1'b0, 0);
      pop_err(4'h2);
      t_readback();
      final_report();
   end
endmodule : testbench

`default_nettype wire
